// ==== tb.sv ====
// tb.sv: self-checking bench for the up/down pwm timer
// assumes udt_timer, its checker and one power stage model on pair a
`timescale 1ns/1ns
module tb;
  reg mclk, reset_n, cyc, stb, we, ext_clk, cap, sync;
  reg [7:0] adr;
  reg [3:0] sel;
  reg [31:0] wdat, rdat, v;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, aa, ab, ba, bb, ca, cb, trig, irq, fault;
  wire [5:0] pwm_oe;
  wire [7:0] gap;
  logic [31:0] exp_q[$], msk_q[$], e, m;
  integer failures = 0, checked = 0, trig_n = 0, i, p;
  udt_timer dut (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .external_count_clock(ext_clk), .capture_input(cap),
    .external_sync_input(sync), .pwm_pair_a_out_a(aa), .pwm_pair_a_out_b(ab),
    .pwm_pair_b_out_a(ba), .pwm_pair_b_out_b(bb), .pwm_pair_c_out_a(ca),
    .pwm_pair_c_out_b(cb), .pwm_oe(pwm_oe), .adc_conv_trigger(trig), .irq(irq));
  udt_power_stage u_stage (.mclk(mclk), .reset_n(reset_n), .in_hi(aa), .in_lo(ab),
    .en_hi(pwm_oe[0]), .en_lo(pwm_oe[1]), .fault(fault), .gap(gap));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ------------------------------------------------
  // checking and closing
  // ------------------------------------------------
  task chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task conclude;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // read data is compared here against the oldest note of the driver
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      chk((wb_dat_o & m) === (e & m), "read data");
    end
  end
  always @(posedge mclk) if (trig === 1'b1) trig_n++;
  initial begin
    repeat (60000) @(posedge mclk);
    chk(1'b0, "run too long");
    conclude;
  end
  // ------------------------------------------------
  // bus cycles
  // ------------------------------------------------
  task bus(input [7:0] a, input w, input [31:0] d);
    integer n;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    if (n >= 50) begin
      chk(1'b0, "no ack");
      conclude;
    end
    {cyc, stb} <= 2'b00;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rd(input [7:0] a, input [31:0] x, input [31:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    bus(a, 1'b0, 32'h0);
  endtask
  task wt(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial begin
    {reset_n, cyc, stb, we, ext_clk, cap, sync, adr, sel, wdat} = 0;
    void'($urandom(46));
    wt(20);
    reset_n <= 1'b1;
    rd(8'h08, 32'hffff, '1);
    wr(8'h1c, 32'h1234);
    rd(8'h1c, 32'h0, '1);
    rd(8'h3c, 32'h0, '1);
    wr(8'h04, 32'hffff);
    rd(8'h04, 32'h0fff, '1);
    for (i = 0; i < 3; i++) begin
      v = $urandom;
      wr(8'(12 + 4 * i), v);
      rd(8'(12 + 4 * i), v & 32'hffff, '1);
    end
    $display("test regs done");
    wr(8'h20, 32'h3f);
    wr(8'h38, 32'h1);
    wt(3);
    chk(pwm_oe === 6'h00, "hiz");
    wr(8'h38, 32'h0);
    wt(3);
    chk(pwm_oe === 6'h3f, "oe back");
    $display("test hiz done");
    // interval run with dead time 5 and all events enabled
    wr(8'h04, 0); wr(8'h08, 60); wr(8'h0c, 20); wr(8'h10, 30); wr(8'h14, 40);
    wr(8'h24, 5); wr(8'h28, 32'h1f); wr(8'h00, 32'h1);
    wt(200);
    chk(irq === 1'b1, "irq");
    chk(gap >= 8'd6 && gap <= 8'd7, "dead time");
    wr(8'h00, 0);
    rd(8'h2c, 32'h0f, '1);
    wr(8'h28, 0); wt(3);
    chk(irq === 1'b0, "irq masked");
    wr(8'h28, 32'h1f); wr(8'h2c, 32'h1f);
    rd(8'h2c, 32'h0, '1);
    wt(3);
    chk(irq === 1'b0, "irq cleared");
    $display("test interval done");
    wr(8'h00, 32'h3);
    wt(300);
    wr(8'h00, 0);
    rd(8'h2c, 32'h1f, '1);
    wr(8'h2c, 32'h1f);
    $display("test b2b done");
    // capture mode: one period event, capture then clear
    wr(8'h08, 200); wr(8'h00, 32'h5);
    wt(250);
    cap <= 1'b1; wt(4); cap <= 1'b0; wt(8);
    rd(8'h1c, 0, 32'hffff_ffe0);
    chk(rdat < 32'd20, "count cleared");
    rd(8'h18, 0, 32'hffff_ff00);
    chk(rdat > 32'd0 && rdat <= 32'd200, "capture value");
    wr(8'h00, 0);
    rd(8'h2c, 32'h01, '1);
    wr(8'h2c, 32'h1f);
    // falling-edge capture: a rising edge taken by mistake would leave a count above 31
    wr(8'h00, 32'h15);
    wt(20);
    cap <= 1'b1;
    wt(30);
    cap <= 1'b0;
    wt(8);
    rd(8'h1c, 0, 32'hffff_ffe0);
    wr(8'h00, 0);
    $display("test capture done");
    wr(8'h08, 60); wr(8'h00, 32'h21);
    wt(100);
    sync <= 1'b1; wt(10);
    chk({aa, ab, ba, bb, ca, cb} === 6'h00, "sync blank");
    sync <= 1'b0;
    // stop first so the count restarts from zero for the external clock check
    wr(8'h00, 0);
    wr(8'h00, 32'h9);
    wt(4);
    for (i = 0; i < 10; i++) begin
      ext_clk <= 1'b1; wt(4); ext_clk <= 1'b0; wt(4);
    end
    rd(8'h1c, 32'd10, '1);
    wr(8'h00, 0);
    $display("test pins done");
    wr(8'h30, 32'h1);
    for (p = 0; p < 4; p += 3) begin
      wr(8'h04, p);
      trig_n = 0;
      wr(8'h00, 32'h1);
      wt(610 * (p + 1));
      wr(8'h00, 0);
      chk(trig_n >= 9 && trig_n <= 11, "trigger count");
    end
    // trigger taken from the count reaching the trigger value, once a period
    wr(8'h04, 0);
    wr(8'h34, 25);
    wr(8'h30, 32'h10);
    trig_n = 0;
    wr(8'h00, 32'h1);
    wt(610);
    wr(8'h00, 0);
    chk(trig_n >= 9 && trig_n <= 11, "trigger value count");
    chk(fault === 1'b0, "shoot through");
    $display("test trigger done");
    conclude;
  end
endmodule // tb

// ==== udt_power_stage.sv ====
// udt_power_stage.sv: one half-bridge of the power stage fed by a pwm pair
// assumes an undriven gate is pulled off, so a released output counts as low
`timescale 1ns/1ns
module udt_power_stage (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // gate inputs and their drive enables
  input wire in_hi,
  input wire in_lo,
  input wire en_hi,
  input wire en_lo,
  // shoot-through flag and last dead time in cycles
  output reg fault,
  output reg [7:0] gap
);
  reg [7:0] off_r;
  wire hi = in_hi & en_hi;
  wire lo = in_lo & en_lo;
  // dead time is the run of cycles with both gates off before one turns on
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fault <= 1'b0;
      gap <= 8'h00;
      off_r <= 8'h00;
    end else begin
      if (hi && lo) fault <= 1'b1;
      if (!hi && !lo) off_r <= (off_r == 8'hff) ? off_r : off_r + 8'h01;
      else begin
        if (off_r != 8'h00) gap <= off_r;
        off_r <= 8'h00;
      end
    end
  end
endmodule // udt_power_stage

// ==== udt_regs.vh ====
// udt_regs.vh: offsets, fields, reset values and timing counts of the up/down pwm timer
// assumes a 32-bit classic wishbone slave with byte addresses and a 100 MHz mclk
`ifndef UDT_REGS_VH
`define UDT_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define UDT_OFF_CTRL 8'h00
`define UDT_OFF_PRESC 8'h04
`define UDT_OFF_PERIOD 8'h08
`define UDT_OFF_CMPA 8'h0c
`define UDT_OFF_CMPB 8'h10
`define UDT_OFF_CMPC 8'h14
`define UDT_OFF_CAPT 8'h18
`define UDT_OFF_COUNT 8'h1c
`define UDT_OFF_OUTCTL 8'h20
`define UDT_OFF_DELAY 8'h24
`define UDT_OFF_INTEN 8'h28
`define UDT_OFF_FLAGS 8'h2c
`define UDT_OFF_ADTC 8'h30
`define UDT_OFF_ADTV 8'h34
`define UDT_OFF_HIZ 8'h38

// ----------------------------------------------------------------
// timer_control fields and modes
// ----------------------------------------------------------------
`define UDT_CTL_RUN 0
`define UDT_CTL_MODE_LO 1
`define UDT_CTL_EXTCLK 3
`define UDT_CTL_CAPFALL 4
`define UDT_CTL_SYNCEN 5
`define UDT_MODE_INTERVAL 2'h0
`define UDT_MODE_B2B 2'h1
`define UDT_MODE_CAPTURE 2'h2

// ----------------------------------------------------------------
// event bits, shared by flags and enables; trigger select shares bits 0-3 and takes the value match at 4
// ----------------------------------------------------------------
`define UDT_EV_PERIOD 0
`define UDT_EV_A 1
`define UDT_EV_B 2
`define UDT_EV_C 3
`define UDT_EV_BOTTOM 4
`define UDT_ADT_VALUE 4

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define UDT_RST_PERIOD 16'hffff
`define UDT_RST_ZERO 16'h0000
`define UDT_START_LAT 2

`endif

// ==== udt_timer.v ====
// udt_timer.v: 16-bit up/down timer with three pwm output pairs, capture,
// adc trigger and interrupt, behind a classic wishbone slave
// assumes pins are asynchronous to mclk; the power stage reads pwm_oe as drive enable
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`include "udt_regs.vh"

module udt_timer #(
  parameter CW = 16,
  parameter PW = 12,
  parameter DW = 8
) (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // pins from outside
  input wire external_count_clock,
  input wire capture_input,
  input wire external_sync_input,
  // pwm pairs and their drive enables
  output wire pwm_pair_a_out_a,
  output wire pwm_pair_a_out_b,
  output wire pwm_pair_b_out_a,
  output wire pwm_pair_b_out_b,
  output wire pwm_pair_c_out_a,
  output wire pwm_pair_c_out_b,
  output reg [5:0] pwm_oe,
  // converter trigger and interrupt
  output reg adc_conv_trigger,
  output reg irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [5:0] timer_control_r;
  reg [PW-1:0] presc_r;
  reg [CW-1:0] period_value_r;
  reg [CW-1:0] compare_a_value_r;
  reg [CW-1:0] compare_b_value_r;
  reg [CW-1:0] compare_c_value_r;
  reg [CW-1:0] capture_value_r;
  reg [CW-1:0] counter_value_r;
  reg [5:0] output_control_r;
  reg [DW-1:0] output_delay_r;
  reg [4:0] inten_r;
  reg [4:0] flags_r;
  reg [4:0] adc_trigger_control_r;
  reg [CW-1:0] adc_trigger_value_r;
  reg hiz_r;
  reg [PW-1:0] pcnt_r;
  reg dir_up_r;
  reg [1:0] run_dly_r;
  reg [2:0] s1_r;
  reg [2:0] s2_r;
  reg [2:0] s3_r;
  reg [2:0] st_r;
  wire [5:0] pwm_q;

  wire run = timer_control_r[`UDT_CTL_RUN];
  wire [1:0] mode = timer_control_r[`UDT_CTL_MODE_LO+1:`UDT_CTL_MODE_LO];
  wire is_b2b = (mode == `UDT_MODE_B2B);
  wire is_cap = (mode == `UDT_MODE_CAPTURE);
  wire run_go = run_dly_r[1];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i;
  // a write lands on the edge where the master sees ack
  wire wr = req & wb_we_i & wb_ack_o;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wd = wb_dat_i & bmask;

  // merge enabled byte lanes into an old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [31:0] m;
    begin
      merge = (old & ~m) | (d & m);
    end
  endfunction
  // control value with lane 0 merged in; only its low six bits are kept
  wire [31:0] ctl_m = merge({26'h0, timer_control_r}, wb_dat_i, bmask);

  reg [31:0] rdata;
  // read mux; unmapped offsets read as zero
  always @* begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      `UDT_OFF_CTRL: rdata[5:0] = timer_control_r;
      `UDT_OFF_PRESC: rdata[PW-1:0] = presc_r;
      `UDT_OFF_PERIOD: rdata[CW-1:0] = period_value_r;
      `UDT_OFF_CMPA: rdata[CW-1:0] = compare_a_value_r;
      `UDT_OFF_CMPB: rdata[CW-1:0] = compare_b_value_r;
      `UDT_OFF_CMPC: rdata[CW-1:0] = compare_c_value_r;
      `UDT_OFF_CAPT: rdata[CW-1:0] = capture_value_r;
      `UDT_OFF_COUNT: rdata[CW-1:0] = counter_value_r;
      `UDT_OFF_OUTCTL: rdata[5:0] = output_control_r;
      `UDT_OFF_DELAY: rdata[DW-1:0] = output_delay_r;
      `UDT_OFF_INTEN: rdata[4:0] = inten_r;
      `UDT_OFF_FLAGS: rdata[4:0] = flags_r;
      `UDT_OFF_ADTC: rdata[4:0] = adc_trigger_control_r;
      `UDT_OFF_ADTV: rdata[CW-1:0] = adc_trigger_value_r;
      `UDT_OFF_HIZ: rdata[0] = hiz_r;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // one wait state: ack in the cycle after the request, dropped after one cycle
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rdata;
    end
  end

  // software-written registers
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timer_control_r <= 6'h00;
      presc_r <= {PW{1'b0}};
      period_value_r <= `UDT_RST_PERIOD;
      compare_a_value_r <= `UDT_RST_ZERO;
      compare_b_value_r <= `UDT_RST_ZERO;
      compare_c_value_r <= `UDT_RST_ZERO;
      output_control_r <= 6'h00;
      output_delay_r <= {DW{1'b0}};
      inten_r <= 5'h00;
      adc_trigger_control_r <= 5'h00;
      adc_trigger_value_r <= `UDT_RST_ZERO;
      hiz_r <= 1'b0;
    end else if (wr) begin
      case (wb_adr_i)
        `UDT_OFF_CTRL: timer_control_r <= ctl_m[5:0];
        `UDT_OFF_PRESC: presc_r <= wd[PW-1:0] | (presc_r & ~bmask[PW-1:0]);
        `UDT_OFF_PERIOD: period_value_r <= wd[CW-1:0] | (period_value_r & ~bmask[CW-1:0]);
        `UDT_OFF_CMPA: compare_a_value_r <= wd[CW-1:0] | (compare_a_value_r & ~bmask[CW-1:0]);
        `UDT_OFF_CMPB: compare_b_value_r <= wd[CW-1:0] | (compare_b_value_r & ~bmask[CW-1:0]);
        `UDT_OFF_CMPC: compare_c_value_r <= wd[CW-1:0] | (compare_c_value_r & ~bmask[CW-1:0]);
        `UDT_OFF_OUTCTL: output_control_r <= wb_sel_i[0] ? wb_dat_i[5:0] : output_control_r;
        `UDT_OFF_DELAY: output_delay_r <= wd[DW-1:0] | (output_delay_r & ~bmask[DW-1:0]);
        `UDT_OFF_INTEN: inten_r <= wb_sel_i[0] ? wb_dat_i[4:0] : inten_r;
        `UDT_OFF_ADTC: adc_trigger_control_r <= wb_sel_i[0] ? wb_dat_i[4:0] : adc_trigger_control_r;
        `UDT_OFF_ADTV: adc_trigger_value_r <= wd[CW-1:0] | (adc_trigger_value_r & ~bmask[CW-1:0]);
        `UDT_OFF_HIZ: hiz_r <= wb_sel_i[0] ? wb_dat_i[0] : hiz_r;
        default: hiz_r <= hiz_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers: bit 0 count clock, 1 capture, 2 sync
  // ----------------------------------------------------------------
  wire [2:0] pin_in = {external_sync_input, capture_input, external_count_clock};
  // a level counts only once the second and third stages agree, filtering one-cycle glitches
  wire [2:0] pin_chg = ~(s2_r ^ s3_r) & (s3_r ^ st_r);
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      st_r <= 3'h0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      st_r <= st_r ^ pin_chg;
    end
  end
  wire ext_edge = pin_chg[0] & s3_r[0];
  // capture edge polarity chosen in timer_control
  wire cap_edge = pin_chg[1] & (s3_r[1] ^ timer_control_r[`UDT_CTL_CAPFALL]);
  wire blank = timer_control_r[`UDT_CTL_SYNCEN] & st_r[2];

  // ----------------------------------------------------------------
  // start latency and prescaler
  // ----------------------------------------------------------------
  // run passes two flops so counting begins two clocks after the enable write
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      run_dly_r <= 2'b00;
    end else begin
      run_dly_r <= {run_dly_r[0], run};
    end
  end

  wire src_ev = timer_control_r[`UDT_CTL_EXTCLK] ? ext_edge : 1'b1;
  wire tick = run_go & src_ev & (pcnt_r == presc_r);
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pcnt_r <= {PW{1'b0}};
    end else if (!run_go || tick) begin
      pcnt_r <= {PW{1'b0}};
    end else if (src_ev) begin
      pcnt_r <= pcnt_r + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  wire at_per = (counter_value_r == period_value_r);
  wire at_zero = (counter_value_r == {CW{1'b0}});
  wire [CW-1:0] cnt_inc = counter_value_r + {{(CW-1){1'b0}}, 1'b1};
  wire [CW-1:0] cnt_dec = counter_value_r - {{(CW-1){1'b0}}, 1'b1};
  // stopping clears the count so every run starts from zero counting up
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      counter_value_r <= {CW{1'b0}};
      capture_value_r <= {CW{1'b0}};
      dir_up_r <= 1'b1;
    end else if (!run_go) begin
      counter_value_r <= {CW{1'b0}};
      dir_up_r <= 1'b1;
    end else if (is_cap && cap_edge) begin
      capture_value_r <= counter_value_r;
      counter_value_r <= {CW{1'b0}};
    end else if (tick) begin
      if (is_b2b) begin
        if (dir_up_r) begin
          if (at_per) begin
            dir_up_r <= 1'b0;
            counter_value_r <= cnt_dec;
          end else begin
            counter_value_r <= cnt_inc;
          end
        end else if (at_zero) begin
          dir_up_r <= 1'b1;
          counter_value_r <= cnt_inc;
        end else begin
          counter_value_r <= cnt_dec;
        end
      end else begin
        counter_value_r <= at_per ? {CW{1'b0}} : cnt_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // match events, flags, interrupt, adc trigger
  // ----------------------------------------------------------------
  wire ev_per = tick & at_per;
  wire ev_a = tick & ~is_cap & (counter_value_r == compare_a_value_r);
  wire ev_b = tick & ~is_cap & (counter_value_r == compare_b_value_r);
  wire ev_c = tick & ~is_cap & (counter_value_r == compare_c_value_r);
  // bottom exists only in back-to-back, so interval and capture never raise it
  wire ev_bot = tick & is_b2b & ~dir_up_r & at_zero;
  wire [4:0] ev = {ev_bot, ev_c, ev_b, ev_a, ev_per};
  wire ev_val = tick & (counter_value_r == adc_trigger_value_r);
  wire [4:0] adt_src = {ev_val, ev_c, ev_b, ev_a, ev_per};
  wire [4:0] flag_clr = (wr && wb_adr_i == `UDT_OFF_FLAGS) ? wd[4:0] : 5'h00;
  // a new event wins over a same-cycle write-one clear
  wire [4:0] flags_nxt = (flags_r & ~flag_clr) | ev;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flags_r <= 5'h00;
      irq <= 1'b0;
      adc_conv_trigger <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      irq <= |(flags_nxt & inten_r);
      adc_conv_trigger <= |(adt_src & adc_trigger_control_r);
    end
  end

  // ----------------------------------------------------------------
  // pwm pairs with dead time
  // ----------------------------------------------------------------
  wire [3*CW-1:0] cmp_all = {compare_c_value_r, compare_b_value_r, compare_a_value_r};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : pair
      reg lvl_r;
      reg [DW-1:0] dcnt_r;
      reg [1:0] q_r;
      // high while below compare: edge-aligned in interval, centred in back-to-back
      wire raw = run_go & (counter_value_r < cmp_all[g*CW +: CW]);
      wire [1:0] en = output_control_r[2*g+1:2*g];
      always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          lvl_r <= 1'b0;
          dcnt_r <= {DW{1'b0}};
          q_r <= 2'b00;
        end else if (raw != lvl_r) begin
          // both sides off while the delay runs, so a pair never overlaps
          lvl_r <= raw;
          dcnt_r <= output_delay_r;
          q_r <= 2'b00;
        end else if (dcnt_r != {DW{1'b0}}) begin
          dcnt_r <= dcnt_r - {{(DW-1){1'b0}}, 1'b1};
          q_r <= 2'b00;
        end else begin
          q_r <= blank ? 2'b00 : ({~lvl_r, lvl_r} & en);
        end
      end
      assign pwm_q[2*g+1:2*g] = q_r;
    end
  endgenerate

  // drive enables drop together while the soft hiz bit is set
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_oe <= 6'h00;
    end else begin
      pwm_oe <= hiz_r ? 6'h00 : output_control_r;
    end
  end

  assign pwm_pair_a_out_a = pwm_q[0];
  assign pwm_pair_a_out_b = pwm_q[1];
  assign pwm_pair_b_out_a = pwm_q[2];
  assign pwm_pair_b_out_b = pwm_q[3];
  assign pwm_pair_c_out_a = pwm_q[4];
  assign pwm_pair_c_out_b = pwm_q[5];

endmodule // udt_timer

// ==== udt_timer_assertions.sv ====
// udt_timer_assertions.sv: port checker for the up/down pwm timer
// assumes only the timer ports; register shadows are rebuilt from bus writes
`timescale 1ns/1ns
module udt_chk (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // pins
  input wire external_sync_input,
  input wire pwm_pair_a_out_a,
  input wire pwm_pair_a_out_b,
  input wire pwm_pair_b_out_a,
  input wire pwm_pair_b_out_b,
  input wire pwm_pair_c_out_a,
  input wire pwm_pair_c_out_b,
  input wire [5:0] pwm_oe,
  input wire adc_conv_trigger,
  input wire irq
);
  reg hiz_r;
  reg syn_r;
  reg [5:0] oc_r;
  reg [4:0] ie_r;
  wire wr0 = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire pwm_any = pwm_pair_a_out_a | pwm_pair_a_out_b | pwm_pair_b_out_a |
    pwm_pair_b_out_b | pwm_pair_c_out_a | pwm_pair_c_out_b;
  // shadows of lane-0 registers, updated at the ack edge like the design
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hiz_r <= 1'b0;
      syn_r <= 1'b0;
      oc_r <= 6'h00;
      ie_r <= 5'h00;
    end else if (wr0) begin
      if (wb_adr_i == 8'h38) hiz_r <= wb_dat_i[0];
      if (wb_adr_i == 8'h00) syn_r <= wb_dat_i[5];
      if (wb_adr_i == 8'h20) oc_r <= wb_dat_i[5:0];
      if (wb_adr_i == 8'h28) ie_r <= wb_dat_i[4:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_pair_excl: assert property (!(pwm_pair_a_out_a && pwm_pair_a_out_b) &&
    !(pwm_pair_b_out_a && pwm_pair_b_out_b) && !(pwm_pair_c_out_a && pwm_pair_c_out_b))
    else $error("pair overlap");
  a_hiz_off: assert property (hiz_r && $past(hiz_r) |-> pwm_oe == 6'h00)
    else $error("hiz not applied");
  a_oe_follow: assert property (!hiz_r && !$past(hiz_r) && oc_r == $past(oc_r)
    |-> pwm_oe == oc_r) else $error("oe mismatch");
  a_irq_cause: assert property (irq |-> $past(ie_r) != 5'h00)
    else $error("irq while all masked");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h38
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_sync_blank: assert property ((syn_r && external_sync_input)[*8] |-> !pwm_any)
    else $error("sync blank failed");
  a_trig_pulse: assert property (adc_conv_trigger |=> !adc_conv_trigger)
    else $error("trigger too long");
  c_hiz: cover property (hiz_r && pwm_oe == 6'h00);
  c_irq: cover property ($rose(irq));
  c_trig: cover property (adc_conv_trigger);
endmodule // udt_chk

bind udt_timer udt_chk u_chk (.mclk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .external_sync_input, .pwm_pair_a_out_a,
  .pwm_pair_a_out_b, .pwm_pair_b_out_a, .pwm_pair_b_out_b, .pwm_pair_c_out_a,
  .pwm_pair_c_out_b, .pwm_oe, .adc_conv_trigger, .irq);
